// file: logic/dbg_trace_pkg.sv
// Constants shared by the debug status and trace port.
// Assumes a single 20 MHz processor clock domain with synchronous reset.
package dbg_trace_pkg;
  // Clock rate and link clock timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned LINK_PERIOD_NS = 400;
  // Serial clock must be seen high this many samples before data is taken
  localparam int unsigned SCLK_HIGH_SAMPLES = 1;
  // Output delay after high validation, in cycles
  localparam int unsigned SO_DELAY_CYCLES = 1;
  // Idle status code, and the start codes that may open the status clock after reset
  localparam logic [3:0] STATUS_IDLE = 4'h0;
  localparam logic [3:0] START_CODE_A = 4'hc;
  localparam logic [3:0] START_CODE_B = 4'hd;
  localparam logic [3:0] START_CODE_C = 4'hf;
  // Reset values
  localparam logic RST_CLK_DISABLE = 1'b0;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  // Buffer depth of the trace path
  localparam int unsigned TRACE_BUF_DEPTH = 2;
endpackage

// file: logic/debug_status_trace_port.sv
// Debug status and trace port: serial debug link and real-time trace pins.
// Assumes core status, trace nibbles and the disable bit come from core logic
// on I_CLK; the debug serial pins come from outside and are synchronised.
// Summary of operation
// RULE1: Synchronise serial input; take after clock high
// RULE2: Serial output registered, updated after high validation
// RULE3: Four-bit trace nibble shows captured data/breakpoints
// RULE4: Host may sample trace on clock out
// RULE5: Status clock delayed, rising mid valid window; the code rises it on the same I_CLK edge that updates the status code
// RULE6: Host samples status and trace at status clock
// RULE7: Disable bit freezes clock and outputs, triggers live
// RULE8: Clearing disable resumes toggling; host resynchronises
// RULE9: Status clock idle until first start code
// RULE10: Status code driven synchronously with processor clock
// RULE11: All-ones indicator is AND of status bits
// RULE12: Clock out follows internal system clock; the code drives a registered divide-by-two copy of I_CLK
// RULE13: Disable bit resets to zero
module debug_status_trace_port
  import dbg_trace_pkg::*;
#(
  parameter int unsigned DEPTH = TRACE_BUF_DEPTH,
  parameter int unsigned W = 4
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_B,
  // Debug serial link pins
  input wire logic I_DEBUG_SERIAL_CLOCK,
  input wire logic I_DEBUG_SERIAL_IN,
  output logic O_DEBUG_SERIAL_OUT,
  // Debug module side of the serial link
  output logic O_RX_BIT_VALID,
  output logic O_RX_BIT,
  input wire logic I_TX_BIT,
  // Core status and trace source
  input wire logic [3:0] I_CORE_STATUS,
  input wire logic I_TRACE_VALID,
  input wire logic [W-1:0] I_TRACE_NIBBLE,
  output logic O_TRACE_READY,
  input wire logic I_STATUS_CLOCK_DISABLE,
  input wire logic I_TRACE_SINK_READY,
  // Trace pins
  output logic [3:0] O_CORE_STATUS_CODE,
  output logic [W-1:0] O_TRACE_DATA_NIBBLE,
  output logic O_STATUS_ALL_ONES,
  output logic O_STATUS_SAMPLE_CLOCK,
  output logic O_SYSTEM_CLOCK_OUT
);

  // Two-stage synchronisers; stage one read by stage two only
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic sin_s1_r, sin_s2_r;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      sin_s1_r <= 1'b0;
      sin_s2_r <= 1'b0;
    end else begin
      sclk_s1_r <= I_DEBUG_SERIAL_CLOCK; // [RULE1]
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      sin_s1_r <= I_DEBUG_SERIAL_IN; // [RULE1]
      sin_s2_r <= sin_s1_r;
    end
  end

  // Rising edge of the synchronised serial clock validates it high
  logic sclk_rise;
  assign sclk_rise = sclk_s2_r & ~sclk_s3_r;

  // Receive: data taken only once the clock is seen high
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_RX_BIT_VALID <= 1'b0;
      O_RX_BIT <= 1'b0;
    end else begin
      O_RX_BIT_VALID <= sclk_rise; // [RULE1]
      if (sclk_rise) begin
        O_RX_BIT <= sin_s2_r; // [RULE1]
      end
    end
  end

  // Transmit: registered, updated one cycle after high validation
  logic so_pend_r;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      so_pend_r <= 1'b0;
      O_DEBUG_SERIAL_OUT <= 1'b0;
    end else begin
      so_pend_r <= sclk_rise;
      if (so_pend_r) begin
        O_DEBUG_SERIAL_OUT <= I_TX_BIT; // [RULE2]
      end
    end
  end

  // Disable bit held in a register; reset clears it
  logic disable_r;
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      disable_r <= RST_CLK_DISABLE; // [RULE13]
    end else begin
      disable_r <= I_STATUS_CLOCK_DISABLE; // [RULE7] [RULE8]
    end
  end

  // Start gate: opens on the first start code after reset
  logic started_r;
  function automatic logic is_start_code(input logic [3:0] c);
    is_start_code = (c == START_CODE_A) || (c == START_CODE_B) || (c == START_CODE_C);
  endfunction
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      started_r <= 1'b0;
    end else if (is_start_code(I_CORE_STATUS)) begin
      started_r <= 1'b1; // [RULE9]
    end
  end

  // Trace buffer: two entries, flip-flop storage by index
  logic [W-1:0] buf_mem_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr_r, rd_ptr_r;
  logic [$clog2(DEPTH):0] count_r;
  logic buf_push, buf_pop, buf_empty, buf_full, live;
  assign live = started_r & ~disable_r;
  assign buf_full = (count_r == DEPTH[$clog2(DEPTH):0]);
  assign buf_empty = (count_r == '0);
  assign buf_push = I_TRACE_VALID & ~buf_full;
  // Sink stall holds the word; frozen outputs drain nothing
  assign buf_pop = ~buf_empty & I_TRACE_SINK_READY & live;
  assign O_TRACE_READY = ~buf_full;

  // Buffer storage writes
  always_ff @(posedge I_CLK) begin
    if (buf_push) begin
      buf_mem_r[wr_ptr_r] <= I_TRACE_NIBBLE;
    end
  end

  // Buffer pointers and fill count
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (buf_push) begin
        wr_ptr_r <= (wr_ptr_r == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (buf_pop) begin
        rd_ptr_r <= (rd_ptr_r == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{$clog2(DEPTH){1'b0}}, buf_push} - {{$clog2(DEPTH){1'b0}}, buf_pop};
    end
  end

  // Status and trace pins: updated on the processor clock, frozen when off
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_CORE_STATUS_CODE <= STATUS_IDLE;
      O_STATUS_ALL_ONES <= 1'b0;
      O_TRACE_DATA_NIBBLE <= RST_NIBBLE;
    end else if (!disable_r) begin
      O_CORE_STATUS_CODE <= I_CORE_STATUS; // [RULE10]
      O_STATUS_ALL_ONES <= &I_CORE_STATUS; // [RULE11]
      // Idle nibble shows zero when no word is waiting
      O_TRACE_DATA_NIBBLE <= buf_pop ? buf_mem_r[rd_ptr_r] : RST_NIBBLE; // [RULE3]
    end
  end

  // Status sample clock: one period per processor clock would need the
  // falling edge; a divide-by-two keeps it register-driven, rising on the edge that updates the code
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_STATUS_SAMPLE_CLOCK <= 1'b0;
    end else if (live) begin
      O_STATUS_SAMPLE_CLOCK <= ~O_STATUS_SAMPLE_CLOCK; // [RULE5] [RULE9] [RULE7]
    end
  end

  // Clock out: registered divide-by-two copy of the system clock
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) begin
      O_SYSTEM_CLOCK_OUT <= 1'b0;
    end else begin
      O_SYSTEM_CLOCK_OUT <= ~O_SYSTEM_CLOCK_OUT; // [RULE12]
    end
  end

endmodule

// file: dv/dbg_host_model.sv
// Development system model: drives the debug serial clock and data.
// Assumes the caller starts frames off the port's clock edges.
module dbg_host_model;
  timeunit 1ns;
  timeprecision 1ns;
  logic sclk = 1'b0; // Stands low between frames
  logic sdi = 1'b0; // Changes only while sclk is low
  // One byte, first bit highest
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      #200 sclk = 1'b1;
      #200 sclk = 1'b0;
    end
    sdi = ~b[0]; // No pull: show the inverse once released
  endtask
endmodule

// file: dv/debug_status_trace_port_monitor.sv
// Checker on the trace port pins, bound into the port.
// Assumes one I_CLK domain with synchronous active-low reset.
module debug_status_trace_port_monitor
  import dbg_trace_pkg::*;
(
  input wire logic I_CLK, I_RST_B, I_DEBUG_SERIAL_CLOCK, I_DEBUG_SERIAL_IN, I_TX_BIT,
  input wire logic I_STATUS_CLOCK_DISABLE, O_DEBUG_SERIAL_OUT, O_RX_BIT_VALID, O_RX_BIT,
  input wire logic O_STATUS_ALL_ONES, O_STATUS_SAMPLE_CLOCK, O_SYSTEM_CLOCK_OUT,
  input wire logic [3:0] I_CORE_STATUS, O_CORE_STATUS_CODE
);
  logic seen_r; // A start code was seen since reset
  always_ff @(posedge I_CLK) begin
    if (!I_RST_B) seen_r <= 1'b0;
    else if (I_CORE_STATUS inside {START_CODE_A, START_CODE_B, START_CODE_C}) seen_r <= 1'b1;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  a_and_of_code: assert property (O_STATUS_ALL_ONES == &O_CORE_STATUS_CODE)
    else $error("all-ones flag differs");
  a_code_follows: assert property ($past(I_RST_B) && !I_STATUS_CLOCK_DISABLE &&
    !$past(I_STATUS_CLOCK_DISABLE) |=> O_CORE_STATUS_CODE == $past(I_CORE_STATUS))
    else $error("status code lost");
  a_code_frozen: assert property (I_STATUS_CLOCK_DISABLE && $past(I_STATUS_CLOCK_DISABLE)
    |=> $stable(O_CORE_STATUS_CODE)) else $error("code moved while frozen");
  a_sclk_frozen: assert property (I_STATUS_CLOCK_DISABLE && $past(I_STATUS_CLOCK_DISABLE)
    |=> $stable(O_STATUS_SAMPLE_CLOCK)) else $error("sample clock moved while frozen");
  a_idle_first: assert property (!seen_r |-> !O_STATUS_SAMPLE_CLOCK)
    else $error("sample clock before start");
  a_sclk_runs: assert property (seen_r && !I_STATUS_CLOCK_DISABLE &&
    !$past(I_STATUS_CLOCK_DISABLE) |=> $changed(O_STATUS_SAMPLE_CLOCK))
    else $error("sample clock stalled");
  a_sys_toggles: assert property ($past(I_RST_B) |=> $changed(O_SYSTEM_CLOCK_OUT))
    else $error("clock out stalled");
  a_rx_after_high: assert property (O_RX_BIT_VALID |-> $past(I_DEBUG_SERIAL_CLOCK, 3) &&
    O_RX_BIT == $past(I_DEBUG_SERIAL_IN, 3)) else $error("bit taken wrongly");
  a_rx_answers: assert property ($rose(I_DEBUG_SERIAL_CLOCK) |-> ##[1:4] O_RX_BIT_VALID)
    else $error("serial rise not taken");
  a_out_updates: assert property (O_RX_BIT_VALID |=> O_DEBUG_SERIAL_OUT == $past(I_TX_BIT))
    else $error("serial out not updated");
  c_rx: cover property (O_RX_BIT_VALID);
  c_all_ones: cover property (O_STATUS_ALL_ONES);
  c_resume: cover property (I_STATUS_CLOCK_DISABLE ##1 !I_STATUS_CLOCK_DISABLE);
endmodule
bind debug_status_trace_port debug_status_trace_port_monitor mon_u (.*);

// file: dv/debug_status_trace_port_bench.sv
// Bench for the trace port: start codes, trace stream, serial link.
// Assumes the host model drives the serial pins.
module debug_status_trace_port_bench;
  import dbg_trace_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, tx = 0, tv = 0, sink = 0, dis = 0, e, so, rxv, rxb, rdy, a1, sck, sy;
  logic [3:0] st = 4'h0, tn = 4'h1, code, nib;
  logic [3:0] q[$]; // Nibbles still owed on the pins
  logic sq[$]; // Serial bits still owed
  logic [3:0] sc[3] = '{START_CODE_A, START_CODE_B, START_CODE_C};
  logic [7:0] b;
  logic d1 = 1'b0, d2 = 1'b0, rst_d = 1'b0; // Freeze seen one and two edges back, reset seen one edge back
  logic [3:0] stp = 4'h0; // Status input at the previous edge
  int miscompares = 0;
  int checks_done = 0;
  always #25 clk = ~clk;
  dbg_host_model host_u();
  debug_status_trace_port dut_u(.I_CLK(clk), .I_RST_B(rst_b),
    .I_DEBUG_SERIAL_CLOCK(host_u.sclk), .I_DEBUG_SERIAL_IN(host_u.sdi),
    .O_DEBUG_SERIAL_OUT(so), .O_RX_BIT_VALID(rxv), .O_RX_BIT(rxb), .I_TX_BIT(tx),
    .I_CORE_STATUS(st), .I_TRACE_VALID(tv), .I_TRACE_NIBBLE(tn), .O_TRACE_READY(rdy),
    .I_STATUS_CLOCK_DISABLE(dis), .I_TRACE_SINK_READY(sink), .O_CORE_STATUS_CODE(code),
    .O_TRACE_DATA_NIBBLE(nib), .O_STATUS_ALL_ONES(a1), .O_STATUS_SAMPLE_CLOCK(sck),
    .O_SYSTEM_CLOCK_OUT(sy));
  task automatic chk(input string n, input logic [3:0] x, input logic [3:0] g);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Oldest note against each result; zero nibble means no word
  // A frozen pin still shows its last word, so only fresh loads are taken
  always @(posedge clk) begin
    if (nib !== 4'h0 && !d2) chk("trace", q.pop_front(), nib);
    if (rxv !== 1'b0) chk("rx", {3'h0, sq.pop_front()}, {3'h0, rxb});
    if (rst_b && rst_d && !d2) chk("code", stp, code);
    if (rst_b && rst_d && !d2) chk("allones", {3'h0, &stp}, {3'h0, a1});
    d2 = d1;
    d1 = dis;
    rst_d = rst_b;
    stp = st;
  end
  initial begin
    void'($urandom(32'h5333d071));
    foreach (sc[i]) begin
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge clk);
      st <= sc[i];
      @(negedge clk) chk("ready", 4'h1, {3'h0, rdy});
      chk("idle", 4'h0, {3'h0, sck});
      repeat (3) @(negedge clk);
      e = sck;
      @(negedge clk) chk("live", {3'h0, ~e}, {3'h0, sck});
    end
    fork
      for (int k = 0; k < 240; k++) begin
        @(posedge clk);
        if (tv && rdy) q.push_back(tn);
        if (!tv || rdy) begin
          tv <= k < 200;
          tn <= 4'($urandom_range(15, 1));
        end
        st <= 4'($urandom);
        tx <= 1'($urandom);
        sink <= k > 200 || 1'($urandom);
        dis <= k % 60 > 50 && k < 200; // Freeze bursts, then resume
      end
      begin
        #13; // Keep link edges away from clk edges
        repeat (4) begin
          b = 8'($urandom);
          for (int i = 7; i >= 0; i--) sq.push_back(b[i]);
          host_u.send(b);
          #400;
        end
      end
    join
    repeat (4) @(posedge clk);
    chk("left", 4'h0, 4'(q.size() + sq.size()));
    finish_test();
  end
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule
